// [logic/plmf_top.sv]
/*
  Pixel post-processing: output LUT and packing, 64-byte line metadata
  appended after each line, and correction entry selection.
  Assumes pixel, line and trigger inputs come from logic on sys_clk_in,
  that camera settings are stable within a line, and that line blanking
  lasts at least 16 cycles so metadata never overlaps the next line.
*/
`timescale 1ns/1ps
`include "plmf_defs.svh"

module plmf_top #(
  parameter int LUT_IN_W = `PLMF_LUT_IN_W,
  parameter int LUT_OUT_W = `PLMF_LUT_OUT_W,
  parameter int NUM_SETS = `PLMF_NUM_SETS,
  parameter int SET_W = `PLMF_SET_W,
  parameter int ENTRY_W = `PLMF_ENTRY_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic line_valid_in,
  input wire logic pix_valid_in,
  input wire logic [23:0] pix_data_in,
  input wire logic lut_enable_in,
  input wire plmf_pkg::plmf_depth_t pixel_depth_in,
  input wire plmf_pkg::plmf_fmt_t out_format_in,
  input wire logic lut_wr_in,
  input wire logic [LUT_IN_W-1:0] lut_addr_in,
  input wire logic [LUT_OUT_W-1:0] lut_data_in,
  input wire logic metadata_enable_in,
  input wire logic enc_fwd_in,
  input wire logic enc_rev_in,
  input wire logic line_trigger_in,
  input wire logic frame_start_in,
  input wire logic [7:0] input_levels_in,
  input wire logic [7:0] output_levels_in,
  input wire logic [7:0] bidir_levels_in,
  input wire logic acq_active_in,
  input wire logic acq_start_in,
  input wire logic [15:0] acq_start_index_in,
  input wire plmf_pkg::plmf_cycle_t correction_cycle_mode_in,
  input wire logic [ENTRY_W-1:0] correction_entry_select_in,
  input wire logic [SET_W-1:0] correction_set_select_in,
  input wire logic set_select_wr_in,
  input wire logic set_cfg_wr_in,
  input wire logic [SET_W-1:0] set_cfg_idx_in,
  input wire logic [ENTRY_W-1:0] set_cfg_base_in,
  input wire logic [ENTRY_W-1:0] set_cfg_len_in,
  output logic out_valid_out,
  output logic out_meta_out,
  output logic [31:0] out_data_out,
  output logic meta_busy_out,
  output logic [ENTRY_W-1:0] correction_entry_out
);
  import plmf_pkg::*;

  if (LUT_IN_W != 12 || LUT_OUT_W != 16) begin : g_chk
    $error("plmf_top: LUT must be 12-in, 16-out");
  end

  function automatic logic [11:0] depth_mask(input plmf_depth_t d);
    return (d == PD_8) ? `PLMF_MASK_8 : (d == PD_10) ? `PLMF_MASK_10 : `PLMF_MASK_12;
  endfunction

  // Pin inputs: two flops before use; third stage only for edge finding
  logic [1:0] fwd_s_q, rev_s_q;
  logic fwd_d3_q, rev_d3_q;
  logic [7:0] in_s1_q, in_s2_q, bd_s1_q, bd_s2_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_s_q <= 2'h0;
      rev_s_q <= 2'h0;
      fwd_d3_q <= 1'b0;
      rev_d3_q <= 1'b0;
      in_s1_q <= 8'h00;
      in_s2_q <= 8'h00;
      bd_s1_q <= 8'h00;
      bd_s2_q <= 8'h00;
    end else begin
      fwd_s_q <= {fwd_s_q[0], enc_fwd_in};
      rev_s_q <= {rev_s_q[0], enc_rev_in};
      fwd_d3_q <= fwd_s_q[1];
      rev_d3_q <= rev_s_q[1];
      in_s1_q <= input_levels_in;
      in_s2_q <= in_s1_q;
      bd_s1_q <= bidir_levels_in;
      bd_s2_q <= bd_s1_q;
    end
  end

  wire fwd_pulse = fwd_s_q[1] & ~fwd_d3_q;
  wire rev_pulse = rev_s_q[1] & ~rev_d3_q;

  // Counters; the _d values are what the record snapshots
  logic [63:0] enc_q, lines_q, trig_q, ts_q;
  logic [31:0] frames_q;
  logic lv_q;

  wire lv_rise = line_valid_in & ~lv_q;
  wire lv_fall = ~line_valid_in & lv_q;
  // Simultaneous forward and reverse pulses cancel
  wire [63:0] enc_d = (fwd_pulse & ~rev_pulse) ? enc_q + 64'h1 :
                      (rev_pulse & ~fwd_pulse) ? enc_q - 64'h1 : enc_q;
  wire [63:0] lines_d = lv_rise ? lines_q + 64'h1 : lines_q;
  wire [63:0] trig_d = line_trigger_in ? trig_q + 64'h1 : trig_q;
  wire [63:0] ts_d = ts_q + 64'h1;
  wire [31:0] frames_d = frame_start_in ? frames_q + 32'h1 : frames_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_q <= `PLMF_CNT_RST;
      lines_q <= `PLMF_CNT_RST;
      trig_q <= `PLMF_CNT_RST;
      ts_q <= `PLMF_CNT_RST;
      frames_q <= `PLMF_FRAME_RST;
      lv_q <= 1'b0;
    end else begin
      enc_q <= enc_d;
      lines_q <= lines_d;
      trig_q <= trig_d;
      ts_q <= ts_d;
      frames_q <= frames_d;
      lv_q <= line_valid_in;
    end
  end

  // Record image, byte 0 in bits 7:0, fields back to back
  localparam int RSV_W = `PLMF_RSV_BYTES * 8;
  wire [511:0] rec_d = {{RSV_W{1'b0}}, bd_s2_q, output_levels_in, in_s2_q,
                        frames_d, ts_d, trig_d, lines_d, enc_d};

  logic [511:0] snap_q, emit_q;
  logic meta_en_line_q;
  plmf_meta_st_t meta_st_q;
  logic [3:0] mcnt_q;

  wire meta_emit = meta_st_q == META_EMIT;
  wire meta_start = lv_fall & meta_en_line_q;

  // Snapshot at line start, not at output time
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      snap_q <= '0;
      meta_en_line_q <= 1'b0;
    end else if (lv_rise) begin
      snap_q <= rec_d;
      meta_en_line_q <= metadata_enable_in;
    end
  end

  // A second copy lets the next line snapshot while this record drains
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_st_q <= META_IDLE;
      emit_q <= '0;
      mcnt_q <= 4'h0;
    end else begin
      unique case (meta_st_q)
        META_IDLE: begin
          if (meta_start) begin
            meta_st_q <= META_EMIT;
            emit_q <= snap_q;
            mcnt_q <= 4'h0;
          end
        end
        META_EMIT: begin
          // Sixteen 32-bit words make the 64-byte record
          emit_q <= {32'h0, emit_q[511:32]};
          mcnt_q <= mcnt_q + 4'h1;
          if (mcnt_q == `PLMF_META_LAST) begin
            meta_st_q <= META_IDLE;
          end
        end
      endcase
    end
  end

  // Pixel path: one cycle through the table
  logic v1_q;
  logic [23:0] raw1_q;
  logic [15:0] l0, l1, l2;
  wire rgb_in = (out_format_in == FMT_RGB888) | (out_format_in == FMT_RGB8888);
  wire [11:0] mono_addr = pix_data_in[11:0] & depth_mask(pixel_depth_in);

  plmf_lut #(
    .AW(LUT_IN_W),
    .DW(LUT_OUT_W)
  ) u_lut (
    .sys_clk_in(sys_clk_in),
    .wr_in(lut_wr_in),
    .waddr_in(lut_addr_in),
    .wdata_in(lut_data_in),
    .raddr0_in(rgb_in ? {4'h0, pix_data_in[7:0]} : mono_addr),
    .raddr1_in({4'h0, pix_data_in[15:8]}),
    .raddr2_in({4'h0, pix_data_in[23:16]}),
    .rdata0_out(l0),
    .rdata1_out(l1),
    .rdata2_out(l2)
  );

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      v1_q <= 1'b0;
      raw1_q <= 24'h0;
    end else begin
      v1_q <= pix_valid_in & line_valid_in;
      raw1_q <= pix_data_in;
    end
  end

  // Packing: table result right-justified bypass packs raw LSBs
  wire [31:0] raw_mono = {20'h0, raw1_q[11:0] & depth_mask(pixel_depth_in)};
  wire [31:0] raw_rgb = {8'h0, raw1_q};
  wire [31:0] lut_rgb = {8'h0, l2[7:0], l1[7:0], l0[7:0]};
  wire [31:0] lut_mono = (out_format_in == FMT_MONO8) ? {24'h0, l0[7:0]} : {16'h0, l0};
  wire rgb1 = (out_format_in == FMT_RGB888) | (out_format_in == FMT_RGB8888);
  wire [31:0] pix_word = lut_enable_in ? (rgb1 ? lut_rgb : lut_mono) : (rgb1 ? raw_rgb : raw_mono);

  logic out_valid_q, out_meta_q, meta_busy_q;
  logic [31:0] out_data_q;

  // Record words follow the last pixel; pixels arriving during the record are lost
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_q <= 1'b0;
      out_meta_q <= 1'b0;
      out_data_q <= 32'h0;
      meta_busy_q <= 1'b0;
    end else begin
      out_valid_q <= meta_emit | v1_q;
      out_meta_q <= meta_emit;
      out_data_q <= meta_emit ? emit_q[31:0] : pix_word;
      meta_busy_q <= meta_start | (meta_emit & (mcnt_q != `PLMF_META_LAST));
    end
  end

  assign out_valid_out = out_valid_q;
  assign out_meta_out = out_meta_q;
  assign out_data_out = out_data_q;
  assign meta_busy_out = meta_busy_q;

  // Entry selection over the set tables
  plmf_corr_sel #(
    .NUM_SETS(NUM_SETS),
    .SET_W(SET_W),
    .ENTRY_W(ENTRY_W)
  ) u_sel (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .frame_start_in(frame_start_in),
    .acq_active_in(acq_active_in),
    .acq_start_in(acq_start_in),
    .acq_start_index_in(acq_start_index_in),
    .cycle_mode_in(correction_cycle_mode_in),
    .entry_select_in(correction_entry_select_in),
    .set_select_in(correction_set_select_in),
    .set_select_wr_in(set_select_wr_in),
    .set_cfg_wr_in(set_cfg_wr_in),
    .set_cfg_idx_in(set_cfg_idx_in),
    .set_cfg_base_in(set_cfg_base_in),
    .set_cfg_len_in(set_cfg_len_in),
    .entry_out(correction_entry_out)
  );

  sequence s_meta_half;
    out_meta_q [*8];
  endsequence

  property p_meta_len;
    @(posedge sys_clk_in) disable iff (rst_in)
      meta_start |-> ##2 s_meta_half ##1 s_meta_half ##1 !out_meta_q;
  endproperty
  a_meta_len: assert property (p_meta_len) else $error("record is not 16 words");

  property p_first_word;
    @(posedge sys_clk_in) disable iff (rst_in)
      meta_start |-> ##2 out_data_q == $past(snap_q[31:0], 2);
  endproperty
  a_first_word: assert property (p_first_word) else $error("record does not open with encoder low word");

  property p_snap;
    @(posedge sys_clk_in) disable iff (rst_in)
      lv_rise |=> snap_q[127:64] == lines_q && snap_q[287:256] == frames_q && snap_q[511:312] == '0;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not taken at line start");

  property p_lines;
    @(posedge sys_clk_in) disable iff (rst_in)
      lv_rise |=> lines_q == $past(lines_q) + 64'h1;
  endproperty
  a_lines: assert property (p_lines) else $error("line count missed a line");

  property p_trig;
    @(posedge sys_clk_in) disable iff (rst_in)
      line_trigger_in |=> trig_q == $past(trig_q) + 64'h1;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger count missed a trigger");

  property p_enc;
    @(posedge sys_clk_in) disable iff (rst_in)
      rev_pulse && !fwd_pulse |=> enc_q == $past(enc_q) - 64'h1;
  endproperty
  a_enc: assert property (p_enc) else $error("reverse pulse did not decrement");

  property p_mono16;
    @(posedge sys_clk_in) disable iff (rst_in)
      v1_q && !meta_emit && lut_enable_in && out_format_in == FMT_MONO16 |=> out_data_q == {16'h0, $past(l0)};
  endproperty
  a_mono16: assert property (p_mono16) else $error("mono16 table result misplaced");

  property p_bypass;
    @(posedge sys_clk_in) disable iff (rst_in)
      v1_q && !meta_emit && !lut_enable_in && out_format_in == FMT_MONO8
        |=> out_data_q == {20'h0, $past(raw1_q[11:0] & depth_mask(pixel_depth_in))};
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass pixel not in low bits");
endmodule

// [logic/plmf_defs.svh]
/*
  Constants of the pixel LUT, line metadata and correction selection stage.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef PLMF_DEFS_SVH
`define PLMF_DEFS_SVH

`define PLMF_LUT_IN_W 12
`define PLMF_LUT_OUT_W 16
`define PLMF_META_WORDS 16
`define PLMF_META_LAST 4'hf
`define PLMF_RSV_BYTES 25
`define PLMF_NUM_SETS 16
`define PLMF_SET_W 4
`define PLMF_ENTRY_W 8
`define PLMF_CNT_RST 64'h0
`define PLMF_FRAME_RST 32'h0
`define PLMF_MASK_8 12'h0ff
`define PLMF_MASK_10 12'h3ff
`define PLMF_MASK_12 12'hfff

`endif

// [logic/plmf_pkg.sv]
/*
  Types shared by the pixel LUT, metadata and correction selection stage.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package plmf_pkg;
  typedef enum logic [1:0] {PD_8, PD_10, PD_12} plmf_depth_t;
  typedef enum logic [1:0] {FMT_MONO8, FMT_MONO16, FMT_RGB888, FMT_RGB8888} plmf_fmt_t;
  typedef enum logic {CYC_OFF, CYC_AUTO} plmf_cycle_t;
  typedef enum logic {META_IDLE, META_EMIT} plmf_meta_st_t;
endpackage

// [logic/plmf_lut.sv]
/*
  Output lookup table: one write port, three registered read ports.
  Assumes all ports are on sys_clk_in; contents are not reset.
*/
`timescale 1ns/1ps
module plmf_lut #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  input wire logic sys_clk_in,
  input wire logic wr_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr0_in,
  input wire logic [AW-1:0] raddr1_in,
  input wire logic [AW-1:0] raddr2_in,
  output logic [DW-1:0] rdata0_out,
  output logic [DW-1:0] rdata1_out,
  output logic [DW-1:0] rdata2_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  if (AW < 8 || AW > 16) begin : g_chk
    $error("plmf_lut: address width out of range");
  end

  // Three ports serve the three colour channels with one shared table
  always_ff @(posedge sys_clk_in) begin
    if (wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata0_out <= mem[raddr0_in];
    rdata1_out <= mem[raddr1_in];
    rdata2_out <= mem[raddr2_in];
  end
endmodule

// [logic/plmf_corr_sel.sv]
/*
  Correction entry selector: fixed or round-robin entry per frame over
  up to 16 sets. Assumes frame_start_in is a one-cycle pulse on sys_clk_in.
*/
`timescale 1ns/1ps
`include "plmf_defs.svh"
module plmf_corr_sel #(
  parameter int NUM_SETS = `PLMF_NUM_SETS,
  parameter int SET_W = `PLMF_SET_W,
  parameter int ENTRY_W = `PLMF_ENTRY_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic frame_start_in,
  input wire logic acq_active_in,
  input wire logic acq_start_in,
  input wire logic [15:0] acq_start_index_in,
  input wire plmf_pkg::plmf_cycle_t cycle_mode_in,
  input wire logic [ENTRY_W-1:0] entry_select_in,
  input wire logic [SET_W-1:0] set_select_in,
  input wire logic set_select_wr_in,
  input wire logic set_cfg_wr_in,
  input wire logic [SET_W-1:0] set_cfg_idx_in,
  input wire logic [ENTRY_W-1:0] set_cfg_base_in,
  input wire logic [ENTRY_W-1:0] set_cfg_len_in,
  output logic [ENTRY_W-1:0] entry_out
);
  import plmf_pkg::*;

  if (NUM_SETS < 1 || NUM_SETS > (1 << SET_W)) begin : g_chk
    $error("plmf_corr_sel: set count does not fit set index");
  end

  // An empty list behaves as a list of one so the modulo never divides by zero
  function automatic logic [ENTRY_W-1:0] safe_len(input logic [ENTRY_W-1:0] l);
    return (l == '0) ? ENTRY_W'(1) : l;
  endfunction

  logic [ENTRY_W-1:0] base_mem [0:NUM_SETS-1];
  logic [ENTRY_W-1:0] len_mem [0:NUM_SETS-1];
  logic [SET_W-1:0] set_q, pend_set_q;
  logic pend_q;
  logic [ENTRY_W-1:0] pos_q, entry_q;

  // Set tables accept writes at any time, acquisition or not
  always_ff @(posedge sys_clk_in) begin
    if (set_cfg_wr_in) begin
      base_mem[set_cfg_idx_in] <= set_cfg_base_in;
      len_mem[set_cfg_idx_in] <= set_cfg_len_in;
    end
  end

  wire use_new = pend_q & ~acq_active_in;
  wire [SET_W-1:0] eff_set = use_new ? pend_set_q : set_q;
  wire [ENTRY_W-1:0] eff_pos = use_new ? '0 : pos_q;
  wire [ENTRY_W-1:0] eff_len = safe_len(len_mem[eff_set]);
  wire [ENTRY_W-1:0] pos_inc = eff_pos + ENTRY_W'(1);
  wire wrap = pos_inc >= eff_len;
  wire take_pend = pend_q & (use_new | wrap);
  wire [SET_W-1:0] start_set = pend_q ? pend_set_q : set_q;
  wire [15:0] start_len = 16'(safe_len(len_mem[start_set]));
  wire [15:0] start_mod = acq_start_index_in % start_len;
  wire auto_fs = frame_start_in & (cycle_mode_in == CYC_AUTO);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      set_q <= '0;
      pend_set_q <= '0;
      pend_q <= 1'b0;
      pos_q <= '0;
      entry_q <= '0;
    end else begin
      if (set_select_wr_in) begin
        pend_set_q <= set_select_in;
      end
      if (acq_start_in) begin
        // Start index modulo the list length
        set_q <= start_set;
        pos_q <= ENTRY_W'(start_mod);
        pend_q <= set_select_wr_in;
      end else if (auto_fs) begin
        // Round-robin, one step per frame; a new set waits for the pass to end while acquiring, otherwise applies at once
        entry_q <= base_mem[eff_set] + eff_pos;
        pos_q <= wrap ? '0 : pos_inc;
        if (take_pend) begin
          // New set starts at its first entry
          set_q <= pend_set_q;
          pos_q <= use_new ? (wrap ? '0 : ENTRY_W'(1)) : '0;
        end
        // A fresh select in the same cycle wins over the consume
        pend_q <= set_select_wr_in | (pend_q & ~take_pend);
      end else begin
        if (frame_start_in) begin
          // Off mode: chosen entry, set ignored
          entry_q <= entry_select_in;
        end
        pend_q <= pend_q | set_select_wr_in;
      end
    end
  end

  // Entry only moves on a frame boundary mode is trusted stable while acquiring
  assign entry_out = entry_q;

  property p_off_entry;
    @(posedge sys_clk_in) disable iff (rst_in)
      frame_start_in && !acq_start_in && cycle_mode_in == CYC_OFF |=> entry_out == $past(entry_select_in);
  endproperty
  a_off_entry: assert property (p_off_entry) else $error("off mode entry not applied");

  property p_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
      !frame_start_in |=> $stable(entry_out);
  endproperty
  a_hold: assert property (p_hold) else $error("entry changed inside a frame");

  property p_step;
    @(posedge sys_clk_in) disable iff (rst_in)
      auto_fs && !acq_start_in && !pend_q && !wrap |=> pos_q == $past(pos_q) + ENTRY_W'(1);
  endproperty
  a_step: assert property (p_step) else $error("round-robin did not step");

  property p_start;
    @(posedge sys_clk_in) disable iff (rst_in)
      acq_start_in |=> pos_q < 16'($past(start_len)) && 16'(pos_q) == $past(acq_start_index_in) % $past(start_len);
  endproperty
  a_start: assert property (p_start) else $error("start entry not index modulo length");
endmodule

// [dv/plmf_cam_model.sv]
/*
  Camera side model: line-valid, pixel strobe and random pixel data.
  Assumes the bench calls send_line and leaves blanking between lines.
*/
`timescale 1ns/1ps
module plmf_cam_model (
  input wire logic sys_clk_in,
  output logic line_valid_out,
  output logic pix_valid_out,
  output logic [23:0] pix_data_out
);
  int seed = 75683;
  int rem = 0;
  initial begin
    line_valid_out = 1'b0;
    pix_valid_out = 1'b0;
    pix_data_out = 24'h0;
  end
  // Idle strobe and data keep toggling so stale values never pass as pixels
  always @(negedge sys_clk_in) begin
    line_valid_out <= rem != 0;
    if (rem != 0) begin
      pix_valid_out <= ($random(seed) & 3) != 0;
      pix_data_out <= 24'($random(seed));
      rem <= rem - 1;
    end else begin
      pix_valid_out <= ~pix_valid_out;
      pix_data_out <= ~pix_data_out;
    end
  end
  task send_line(input int n);
    rem <= n;
    do @(negedge sys_clk_in); while (rem != 0);
  endtask
endmodule

// [dv/plmf_top_test.sv]
/*
  Self-checking bench: reference model of pixels, line records and entries.
  Assumes the camera model drives the pixel inputs on falling edges.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module plmf_top_test;
  import plmf_pkg::*;
  logic sys_clk_in, rst_in, line_valid_in, pix_valid_in, lut_enable_in, lut_wr_in, metadata_enable_in;
  logic enc_fwd_in, enc_rev_in, line_trigger_in, frame_start_in, acq_active_in, acq_start_in;
  logic set_select_wr_in, set_cfg_wr_in, out_valid_out, out_meta_out, meta_busy_out;
  logic [23:0] pix_data_in;
  logic [11:0] lut_addr_in;
  logic [15:0] lut_data_in, acq_start_index_in;
  logic [7:0] input_levels_in, output_levels_in, bidir_levels_in, correction_entry_select_in;
  logic [7:0] set_cfg_base_in, set_cfg_len_in, correction_entry_out, exp_e;
  logic [3:0] correction_set_select_in, set_cfg_idx_in;
  logic [31:0] out_data_out, frames_c = 0;
  logic [63:0] enc_c = 0, lines_c = 0, trig_c = 0, ts_c = 0;
  logic [511:0] snap;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  logic [15:0] lutm [4096];
  logic [7:0] base_m [16];
  plmf_depth_t pixel_depth_in;
  plmf_fmt_t out_format_in;
  plmf_cycle_t correction_cycle_mode_in;
  int len_m [16];
  int cur = 0, pend = 0, pos = 0, cyc = 0, seed = 75683, bad_count = 0, tests_run = 0, busy_n = 0;
  bit pend_ok = 0, chk_e = 0, lv_prev = 0, meta_on = 0;

  plmf_top u_dut (.sys_clk_in, .rst_in, .line_valid_in, .pix_valid_in, .pix_data_in, .lut_enable_in,
    .pixel_depth_in, .out_format_in, .lut_wr_in, .lut_addr_in, .lut_data_in, .metadata_enable_in,
    .enc_fwd_in, .enc_rev_in, .line_trigger_in, .frame_start_in, .input_levels_in, .output_levels_in,
    .bidir_levels_in, .acq_active_in, .acq_start_in, .acq_start_index_in, .correction_cycle_mode_in,
    .correction_entry_select_in, .correction_set_select_in, .set_select_wr_in, .set_cfg_wr_in,
    .set_cfg_idx_in, .set_cfg_base_in, .set_cfg_len_in, .out_valid_out, .out_meta_out, .out_data_out,
    .meta_busy_out, .correction_entry_out);
  plmf_cam_model u_cam (.sys_clk_in, .line_valid_out(line_valid_in), .pix_valid_out(pix_valid_in),
    .pix_data_out(pix_data_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [31:0] pix_exp(input logic [23:0] d);
    logic [11:0] m;
    m = d[11:0] & (pixel_depth_in == PD_8 ? 12'h0ff : pixel_depth_in == PD_10 ? 12'h3ff : 12'hfff);
    if (out_format_in == FMT_MONO8 || out_format_in == FMT_MONO16) begin
      if (!lut_enable_in) return {20'h0, m};
      return out_format_in == FMT_MONO8 ? {24'h0, lutm[m][7:0]} : {16'h0, lutm[m]};
    end
    if (!lut_enable_in) return {8'h0, d};
    return {8'h0, lutm[d[23:16]][7:0], lutm[d[15:8]][7:0], lutm[d[7:0]][7:0]};
  endfunction

  // Reference model, fed from the inputs as the design samples them
  always @(posedge sys_clk_in) begin
    if (!rst_in) begin
      ts_c++;
      if (frame_start_in) frames_c++;
      if (line_trigger_in) trig_c++;
      if (set_cfg_wr_in) begin
        base_m[set_cfg_idx_in] = set_cfg_base_in;
        len_m[set_cfg_idx_in] = set_cfg_len_in == 8'h0 ? 1 : int'(set_cfg_len_in);
      end
      if (set_select_wr_in && acq_active_in) begin
        pend = correction_set_select_in;
        pend_ok = 1;
      end else if (set_select_wr_in) begin
        cur = correction_set_select_in;
        pos = 0;
        pend_ok = 0;
      end
      if (acq_start_in) begin
        if (pend_ok) cur = pend;
        pend_ok = 0;
        pos = acq_start_index_in % len_m[cur];
      end else if (frame_start_in) begin
        chk_e = 1;
        if (correction_cycle_mode_in == CYC_OFF) exp_e = correction_entry_select_in;
        else begin
          exp_e = 8'(base_m[cur] + pos);
          pos++;
          if (pos >= len_m[cur]) begin
            pos = 0;
            if (pend_ok) cur = pend;
            pend_ok = 0;
          end
        end
      end
      if (line_valid_in && !lv_prev) begin
        lines_c++;
        meta_on = metadata_enable_in;
        snap = {200'h0, bidir_levels_in, output_levels_in, input_levels_in, frames_c, ts_c, trig_c, lines_c, enc_c};
      end
      if (line_valid_in && pix_valid_in) exp_q.push_back({1'b0, pix_exp(pix_data_in)});
      if (!line_valid_in && lv_prev && meta_on) for (int k = 0; k < 16; k++) exp_q.push_back({1'b1, snap[32*k +: 32]});
      lv_prev = line_valid_in;
    end
  end

  always @(negedge sys_clk_in) begin
    if (meta_busy_out === 1'b1) busy_n++;
    if (out_valid_out === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 33'bx;
      `CHK({out_meta_out, out_data_out}, e)
    end
    if (chk_e) begin
      `CHK(correction_entry_out, exp_e)
      chk_e = 0;
    end
  end

  // Ceiling well above the roughly 6000 cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic enc(input bit f);
    enc_fwd_in = f;
    enc_rev_in = !f;
    tick(2);
    {enc_fwd_in, enc_rev_in} = 2'h0;
    tick(2);
    enc_c = f ? enc_c + 64'h1 : enc_c - 64'h1;
  endtask
  task automatic cfg(input logic [3:0] i, input logic [7:0] b, input logic [7:0] l);
    {set_cfg_idx_in, set_cfg_base_in, set_cfg_len_in, set_cfg_wr_in} = {i, b, l, 1'b1};
    tick(1);
    set_cfg_wr_in = 0;
    tick(1);
  endtask
  task automatic sel(input logic [3:0] s);
    {correction_set_select_in, set_select_wr_in} = {s, 1'b1};
    tick(1);
    set_select_wr_in = 0;
  endtask
  task automatic fr;
    frame_start_in = 1;
    tick(1);
    frame_start_in = 0;
    tick(3);
  endtask
  task automatic start(input logic [15:0] x);
    {acq_active_in, acq_start_index_in, acq_start_in} = {1'b0, x, 1'b1};
    tick(1);
    {acq_start_in, acq_active_in} = 2'h1;
  endtask

  initial begin
    {lut_enable_in, lut_wr_in, metadata_enable_in, enc_fwd_in, enc_rev_in, line_trigger_in} = '0;
    {frame_start_in, acq_active_in, acq_start_in, set_select_wr_in, set_cfg_wr_in, lut_addr_in} = '0;
    {lut_data_in, acq_start_index_in, input_levels_in, output_levels_in, bidir_levels_in} = '0;
    {correction_entry_select_in, set_cfg_base_in, set_cfg_len_in, correction_set_select_in, set_cfg_idx_in} = '0;
    pixel_depth_in = PD_8;
    out_format_in = FMT_MONO8;
    correction_cycle_mode_in = CYC_OFF;
    foreach (len_m[i]) len_m[i] = 1;
    rst_in = 1;
    tick(12);
    rst_in = 0;
    for (int i = 0; i < 4096; i++) begin
      {lut_addr_in, lut_data_in, lut_wr_in} = {12'(i), 16'(i * 40503 + 7), 1'b1};
      lutm[i] = lut_data_in;
      tick(1);
    end
    lut_wr_in = 0;
    $display("table load done");
    for (int k = 0; k < 24; k++) begin
      lut_enable_in = k[0];
      out_format_in = plmf_fmt_t'(k[2:1]);
      pixel_depth_in = plmf_depth_t'(k[4:3]);
      metadata_enable_in = 1'($random(seed));
      {input_levels_in, output_levels_in, bidir_levels_in} = 24'($random(seed));
      correction_entry_select_in = 8'($random(seed));
      sel(4'($random(seed)));
      repeat (2) enc(0);
      repeat (k % 3) enc(1);
      line_trigger_in = 1;
      tick(1);
      line_trigger_in = 0;
      fr();
      tick(6);
      u_cam.send_line(16);
      tick(24);
      `CHK(busy_n, metadata_enable_in ? 16 : 0)
      busy_n = 0;
    end
    $display("pixel and record lines done");
    correction_cycle_mode_in = CYC_AUTO;
    cfg(0, 8'h10, 8'h03);
    cfg(15, 8'hf0, 8'h04);
    sel(0);
    start(16'h0005);
    fr();
    sel(15);
    repeat (6) fr();
    cfg(1, 8'h40, 8'h02);
    start(16'h0007);
    repeat (3) fr();
    cfg(2, 8'h80, 8'h00);
    acq_active_in = 0;
    sel(2);
    start(16'h0003);
    repeat (2) fr();
    acq_active_in = 0;
    correction_cycle_mode_in = CYC_OFF;
    fr();
    $display("correction entry sequence done");
    tick(40);
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule
